// >>> inc/bsr_consts.svh
// Addresses, field positions, limits and reset values of the boiler status bank
`ifndef BSR_CONSTS_SVH
`define BSR_CONSTS_SVH

`define BSR_ADDR_CHANGE 16'h0000
`define BSR_ADDR_DEMAND 16'h0006
`define BSR_ADDR_OUTLET 16'h0007
`define BSR_ADDR_FIRING 16'h0008
`define BSR_ADDR_BLOWER 16'h0009
`define BSR_ADDR_FLAME 16'h000A
`define BSR_ADDR_INLET 16'h000B
`define BSR_ADDR_HOT_WATER 16'h000C
`define BSR_ADDR_OUTDOOR 16'h000D
`define BSR_ADDR_FLUE 16'h000E
`define BSR_ADDR_HEADER 16'h000F
`define BSR_ADDR_SP_HEAT 16'h0010
`define BSR_ADDR_SP_HOT_WATER 16'h0011
`define BSR_ADDR_SP_STAGING 16'h0012
`define BSR_ADDR_RSVD_FIRST 16'h0013
`define BSR_ADDR_RSVD_LAST 16'h001F
`define BSR_ADDR_BURNER_STATUS 16'h0020
`define BSR_ADDR_SEQ_STATE 16'h0021
`define BSR_ADDR_LOCKOUT 16'h0022
`define BSR_ADDR_ALARM 16'h0023
`define BSR_ADDR_MODEL 16'h00B0

`define BSR_CHG_RSVD_ONES 16'hF800
`define BSR_CHG_BIT_DEMAND 3
`define BSR_CHG_BIT_BURNER 1

`define BSR_TEMP_MIN 16'hFE70
`define BSR_TEMP_MAX 16'h0514
`define BSR_FLAME_MAX 16'h05DC
`define BSR_LOCKOUT_MAX 16'h1000

`define BSR_ALARM_NONE 16'h0000
`define BSR_ALARM_LOCKOUT 16'h0001
`define BSR_ALARM_ALERT 16'h0002

`define BSR_WORD_RESET 16'h0000
`define BSR_CHANGE_RESET 16'h0000

`endif

// >>> inc/bsr_pkg.sv
// Types of the boiler status bank
package bsr_pkg;

  localparam int NWORDS = 18;

  // Demand sources reported to the master
  typedef enum logic [2:0] {
    BSR_DEM_UNKNOWN = 3'h0,
    BSR_DEM_NONE = 3'h1,
    BSR_DEM_CENTRAL_HEAT = 3'h2,
    BSR_DEM_DOMESTIC_HOT_WATER = 3'h3,
    BSR_DEM_LEAD_LAG_STAGING = 3'h4,
    BSR_DEM_HEAT_FROST = 3'h5,
    BSR_DEM_HOT_WATER_FROST = 3'h6,
    BSR_DEM_SWITCH_OFF = 3'h7
  } bsr_demand_t;

  // Burner-control overall status codes
  typedef enum logic [4:0] {
    BSR_BC_DISABLED = 5'h00,
    BSR_BC_LOCKED_OUT = 5'h01,
    BSR_BC_STANDBY_HOLD = 5'h02,
    BSR_BC_UNCONFIGURED = 5'h03,
    BSR_BC_NORMAL_STANDBY = 5'h10,
    BSR_BC_PREPARING = 5'h11,
    BSR_BC_FIRING = 5'h12,
    BSR_BC_POSTPURGE = 5'h13
  } bsr_burner_status_t;

  // Whole state of the bank
  typedef struct packed {
    logic [NWORDS-1:0][15:0] word;
    logic [15:0] change;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_err;
    logic wr_ack;
  } bsr_state_t;

endpackage : bsr_pkg

// >>> src/bsr_status_bank.sv
// Read-only boiler status register bank with change indicator
//
// Overview of operation
// RULE1: demand source reported as code 0..7, unknown through burner switch off.
// RULE2: active central-heat setpoint, 0.1 degree, -40..130, from configured source.
// RULE3: active hot-water setpoint, same format, from configured source.
// RULE4: active staging setpoint, same format, from configured source.
// RULE5: flame signal in hundredths, limited to 0.00..15.00.
// RULE6: burner status codes 0..3 and 16..19; 4..15 reserved.
// RULE7: sequence state reported raw; model type readable in its own register.
// RULE8: lockout code zero when none, otherwise 1..4096.
// RULE9: alarm cause 0 none, 1 lockout, 2 other alert.
// RULE10: group change bit set when any group register changes value.
// RULE11: change register cleared on read; bit 3 demand, bit 1 burner.
// RULE12: reserved gap reads zero; all writes ignored.
`timescale 1ns/1ns
`include "bsr_consts.svh"

module bsr_status_bank (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Demand and measurements
  input wire logic [2:0] demand_origin_in,
  input wire logic [5:0][15:0] temp_in,
  input wire logic [15:0] firing_rate_in,
  input wire logic [15:0] blower_speed_in,
  input wire logic [15:0] flame_level_in,
  // Setpoint candidates, index 0 heat, 1 hot water, 2 staging
  input wire logic [2:0][15:0] setpoint_local_in,
  input wire logic [2:0][15:0] setpoint_remote_in,
  input wire logic [2:0] setpoint_src_remote,
  // Burner control
  input wire logic [4:0] burner_status_in,
  input wire logic [15:0] sequence_state_in,
  input wire logic model_commercial,
  input wire logic [15:0] lockout_in,
  input wire logic alert_active,
  // Register access
  input wire logic rd_req,
  input wire logic [15:0] rd_addr,
  input wire logic wr_req,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic rd_err,
  output logic wr_ack
);

  ////////////////////////////////////////////////////////////////////////////////

  // Address of each stored word
  function automatic logic [15:0] bsr_addr_of(input int idx);
    logic [15:0] a;
    a = `BSR_ADDR_MODEL;
    if (idx < 13) begin
      a = 16'(`BSR_ADDR_DEMAND + idx);
    end else if (idx < 17) begin
      a = 16'(`BSR_ADDR_BURNER_STATUS + idx - 13);
    end
    return a;
  endfunction : bsr_addr_of

  // Signed clamp to the reported temperature range
  function automatic logic [15:0] bsr_clamp_temp(input logic [15:0] t);
    logic [15:0] r;
    r = t;
    if ($signed(t) < $signed(`BSR_TEMP_MIN)) begin
      r = `BSR_TEMP_MIN;
    end else if ($signed(t) > $signed(`BSR_TEMP_MAX)) begin
      r = `BSR_TEMP_MAX;
    end
    return r;
  endfunction : bsr_clamp_temp

  function automatic logic bsr_status_ok(input logic [4:0] s);
    logic ok;
    ok = 1'b0;
    case (s)
      bsr_pkg::BSR_BC_DISABLED, bsr_pkg::BSR_BC_LOCKED_OUT, bsr_pkg::BSR_BC_STANDBY_HOLD,
      bsr_pkg::BSR_BC_UNCONFIGURED, bsr_pkg::BSR_BC_NORMAL_STANDBY, bsr_pkg::BSR_BC_PREPARING,
      bsr_pkg::BSR_BC_FIRING, bsr_pkg::BSR_BC_POSTPURGE: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : bsr_status_ok

  ////////////////////////////////////////////////////////////////////////////////

  bsr_pkg::bsr_state_t s_reg;
  bsr_pkg::bsr_state_t s_next;
  logic [bsr_pkg::NWORDS-1:0][15:0] w;
  logic [15:0] lock_val;
  logic dem_chg;
  logic bur_chg;

  always_comb begin
    s_next = s_reg;
    w = '0;
    // RULE1: demand code
    w[0] = {13'h0000, demand_origin_in};
    w[1] = bsr_clamp_temp(temp_in[0]);
    w[2] = firing_rate_in;
    w[3] = blower_speed_in;
    // RULE5: flame limited
    w[4] = (flame_level_in > `BSR_FLAME_MAX) ? `BSR_FLAME_MAX : flame_level_in;
    for (int i = 1; i < 6; i++) begin
      w[4 + i] = bsr_clamp_temp(temp_in[i]);
    end
    // RULE2: heat setpoint source
    // RULE3: hot-water setpoint source
    // RULE4: staging setpoint source
    for (int i = 0; i < 3; i++) begin
      w[10 + i] = bsr_clamp_temp(setpoint_src_remote[i] ? setpoint_remote_in[i]
                                                        : setpoint_local_in[i]);
    end
    // RULE6: reserved codes shown as disabled
    w[13] = bsr_status_ok(burner_status_in) ? {11'h000, burner_status_in} : 16'h0000;
    // RULE7: sequence state and model
    w[14] = sequence_state_in;
    // RULE8: lockout saturates at top code
    lock_val = (lockout_in > `BSR_LOCKOUT_MAX) ? `BSR_LOCKOUT_MAX : lockout_in;
    w[15] = lock_val;
    // RULE9: alarm cause, lockout first
    if (lock_val != 16'h0000) begin
      w[16] = `BSR_ALARM_LOCKOUT;
    end else if (alert_active) begin
      w[16] = `BSR_ALARM_ALERT;
    end else begin
      w[16] = `BSR_ALARM_NONE;
    end
    w[17] = {15'h0000, model_commercial};

    // RULE10: compare against published words
    dem_chg = 1'b0;
    bur_chg = 1'b0;
    for (int i = 0; i < bsr_pkg::NWORDS; i++) begin
      if (w[i] != s_reg.word[i]) begin
        if (i < 13) begin
          dem_chg = 1'b1;
        end else begin
          bur_chg = 1'b1;
        end
      end
    end
    s_next.word = w;

    s_next.rd_valid = rd_req;
    s_next.rd_err = 1'b0;
    s_next.rd_data = 16'h0000;
    // RULE12: writes answered, never stored
    s_next.wr_ack = wr_req;
    if (rd_req) begin
      if (rd_addr == `BSR_ADDR_CHANGE) begin
        // RULE11: read returns then clears
        s_next.rd_data = s_reg.change | `BSR_CHG_RSVD_ONES;
        s_next.change = `BSR_CHANGE_RESET;
      end else if (rd_addr >= `BSR_ADDR_RSVD_FIRST && rd_addr <= `BSR_ADDR_RSVD_LAST) begin
        // RULE12: reserved gap reads zero
        s_next.rd_data = 16'h0000;
      end else begin
        s_next.rd_err = 1'b1;
        for (int i = 0; i < bsr_pkg::NWORDS; i++) begin
          if (rd_addr == bsr_addr_of(i)) begin
            s_next.rd_data = s_reg.word[i];
            s_next.rd_err = 1'b0;
          end
        end
      end
    end
    // Set after clear, so a change in the read cycle is not lost
    if (dem_chg) begin
      s_next.change[`BSR_CHG_BIT_DEMAND] = 1'b1;
    end
    if (bur_chg) begin
      s_next.change[`BSR_CHG_BIT_BURNER] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_valid = s_reg.rd_valid;
  assign rd_data = s_reg.rd_data;
  assign rd_err = s_reg.rd_err;
  assign wr_ack = s_reg.wr_ack;

endmodule : bsr_status_bank

// >>> sim/bsr_status_bank_asserts.sv
// Port assertions of the boiler status bank
`timescale 1ns/1ns
module bsr_status_bank_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register access
  input wire logic rd_req,
  input wire logic [15:0] rd_addr,
  input wire logic wr_req,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic rd_err,
  input wire logic wr_ack
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_answer_one_cycle:
    assert property (rd_valid == $past(rd_req) && wr_ack == $past(wr_req)) else $error("late");
  a_demand_code:
    assert property (rd_req && rd_addr == 16'h0006 |=> rd_data <= 16'h0007) else $error("demand");
  a_setpoint_range:
    assert property (rd_req && rd_addr inside {[16'h0010:16'h0012]} |=>
      $signed(rd_data) >= -400 && $signed(rd_data) <= 1300) else $error("setpoint");
  a_flame_limit:
    assert property (rd_req && rd_addr == 16'h000A |=> rd_data <= 16'h05DC) else $error("flame");
  a_burner_code:
    assert property (rd_req && rd_addr == 16'h0020 |=> rd_data <= 16'h0013 &&
      !(rd_data inside {[16'h0004:16'h000F]})) else $error("burner");
  a_lockout_limit:
    assert property (rd_req && rd_addr == 16'h0022 |=> rd_data <= 16'h1000) else $error("lock");
  a_alarm_code:
    assert property (rd_req && rd_addr == 16'h0023 |=> rd_data <= 16'h0002) else $error("alarm");
  a_change_ones:
    assert property (rd_req && rd_addr == 16'h0000 |=> rd_data[15:11] == 5'h1F) else $error("chg");
  a_gap_zero:
    assert property (rd_req && rd_addr inside {[16'h0013:16'h001F]} |=>
      rd_data == 16'h0000 && !rd_err) else $error("gap");
endmodule : bsr_status_bank_asserts

// >>> sim/bsr_master_model.sv
// Register bus master model
`timescale 1ns/1ns
module bsr_master_model (
  // Clock
  input wire logic clk_sys,
  // Register access
  output logic rd_req,
  output logic [15:0] rd_addr,
  output logic wr_req,
  input wire logic [15:0] rd_data
);
  initial begin
    rd_req = 1'b0;
    rd_addr = 16'hFFFF;
    wr_req = 1'b0;
  end
  task rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    rd_req = 1'b1;
    rd_addr = a;
    @(negedge clk_sys);
    rd_req = 1'b0;
    // Released address flips so a stale value cannot pass
    rd_addr = ~a;
    d = rd_data;
  endtask : rd
  task wr();
    @(negedge clk_sys);
    wr_req = 1'b1;
    @(negedge clk_sys);
    wr_req = 1'b0;
  endtask : wr
endmodule : bsr_master_model

// >>> sim/tb_bsr_status_bank.sv
// Testbench of the boiler status bank
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("mismatch %0t got %h", $time, a); end end
module tb_bsr_status_bank;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [2:0] demand_origin_in = '0;
  logic [5:0][15:0] temp_in = '0;
  logic [15:0] firing_rate_in = '0;
  logic [15:0] blower_speed_in = '0;
  logic [15:0] flame_level_in = '0;
  logic [2:0][15:0] setpoint_local_in = '0;
  logic [2:0][15:0] setpoint_remote_in = '0;
  logic [2:0] setpoint_src_remote = '0;
  logic [4:0] burner_status_in = '0;
  logic [15:0] sequence_state_in = '0;
  logic model_commercial = 1'b0;
  logic [15:0] lockout_in = '0;
  logic alert_active = 1'b0;
  logic rd_req;
  logic [15:0] rd_addr;
  logic wr_req;
  logic rd_valid;
  logic [15:0] rd_data;
  logic rd_err;
  logic wr_ack;
  logic [15:0] d;
  logic [4:0] bc [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h11, 5'h12, 5'h13, 5'h05};
  int failures = 0;
  int samples_checked = 0;
  bsr_status_bank u_bsr_status_bank (.*);
  bsr_master_model u_bsr_master_model (.*);
  always #25 clk_sys = ~clk_sys;
  task chk(input logic [15:0] a, input logic [15:0] e);
    u_bsr_master_model.rd(a, d);
    `CHK(d, e)
  endtask : chk
  task t_demand();
    for (int i = 0; i < 8; i++) begin
      demand_origin_in = 3'(i);
      chk(16'h0006, 16'(i));
    end
    $display("demand done");
  endtask : t_demand
  task t_setpoint();
    setpoint_local_in = {16'h0190, 16'h0258, 16'h0320};
    setpoint_remote_in = {16'hFE00, 16'h0514, 16'h0600};
    setpoint_src_remote = 3'b001;
    chk(16'h0010, 16'h0514);
    chk(16'h0011, 16'h0258);
    chk(16'h0012, 16'h0190);
    setpoint_src_remote = 3'b110;
    chk(16'h0010, 16'h0320);
    chk(16'h0011, 16'h0514);
    chk(16'h0012, 16'hFE70);
    $display("setpoint done");
  endtask : t_setpoint
  task t_burner();
    for (int i = 0; i < 9; i++) begin
      burner_status_in = bc[i];
      chk(16'h0020, (i == 8) ? 16'h0000 : {11'h000, bc[i]});
    end
    sequence_state_in = 16'h1234;
    model_commercial = 1'b1;
    chk(16'h0021, 16'h1234);
    chk(16'h00B0, 16'h0001);
    $display("burner done");
  endtask : t_burner
  task t_lockout();
    chk(16'h0023, 16'h0000);
    alert_active = 1'b1;
    chk(16'h0023, 16'h0002);
    lockout_in = 16'h2000;
    chk(16'h0022, 16'h1000);
    chk(16'h0023, 16'h0001);
    flame_level_in = 16'h0700;
    chk(16'h000A, 16'h05DC);
    $display("lockout done");
  endtask : t_lockout
  task t_change();
    u_bsr_master_model.rd(16'h0000, d);
    chk(16'h0000, 16'hF800);
    flame_level_in = 16'h05DB;
    chk(16'h0000, 16'hF808);
    burner_status_in = 5'h12;
    chk(16'h0000, 16'hF802);
    chk(16'h0000, 16'hF800);
    $display("change done");
  endtask : t_change
  task t_gap();
    chk(16'h0013, 16'h0000);
    chk(16'h001F, 16'h0000);
    `CHK(rd_err, 1'b0)
    u_bsr_master_model.wr();
    `CHK(wr_ack, 1'b1)
    chk(16'h0021, 16'h1234);
    `CHK(rd_valid, 1'b1)
    chk(16'h0040, 16'h0000);
    `CHK(rd_err, 1'b1)
    $display("gap done");
  endtask : t_gap
  task finish_test();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    t_demand();
    t_setpoint();
    t_burner();
    t_lockout();
    t_change();
    t_gap();
    finish_test();
  end
  // Guard against a hung run
  initial begin
    #400000;
    failures++;
    finish_test();
  end
endmodule : tb_bsr_status_bank
bind bsr_status_bank bsr_status_bank_asserts u_bsr_status_bank_asserts (.*);
